// File: verilog/vst_pkg.sv
// Shared constants and carrier types for the servo timer unit
package vst_pkg;
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned CLK_NS         = 20;
  localparam int unsigned FRC_RES_NS     = 125;
  localparam int unsigned HEAD_RES_NS    = 1000;
  localparam int unsigned REMOTE_RES_NS  = 2000;
  localparam int unsigned PWM_CARRIER_HZ = 62_500;
  localparam int unsigned PWM_PERIOD_CYC = CLK_HZ / PWM_CARRIER_HZ;
  localparam int          CARRIER_W      = 10;
  localparam int          TICK_N         = 3;
  localparam int          TICK_FRC       = 0;
  localparam int          TICK_US        = 1;
  localparam int          TICK_2US       = 2;
  localparam int unsigned TICK_NS [TICK_N] = '{FRC_RES_NS, HEAD_RES_NS, REMOTE_RES_NS};
  localparam int          ACC_W          = 12;
  localparam int          FRC_W          = 22;
  localparam int          EV_W           = 8;
  localparam int          TMR_W          = 16;
  localparam int          TAPE_W         = 5;
  localparam int          FINE_W         = 16;
  localparam int          COARSE_W       = 8;
  localparam int          NUM_CAPT       = 6;
  localparam int          NUM_PWM        = 3;
  localparam int          PIN_W          = 9;
  localparam logic [FRC_W-1:0]  FRC_RST  = 22'h000000;
  localparam logic [TMR_W-1:0]  TMR_RST  = 16'h0000;
  localparam logic [EV_W-1:0]   EV_RST   = 8'h00;
  localparam logic [TAPE_W-1:0] TAPE_RST = 5'h00;

  typedef struct packed {
    logic drum_phase_pulse;
    logic drum_speed_pulse;
    logic capstan_speed_pulse;
    logic reel_speed_a;
    logic reel_speed_b;
    logic vsync_in;
    logic hsync_in;
    logic playback_control_pulse;
    logic remote_edge_input;
  } vst_pins_t;

  typedef struct packed {
    logic [3:0][EV_W-1:0]         head_event_cmp;
    logic [TMR_W-1:0]             video_switch_cmp;
    logic [TMR_W-1:0]             audio_switch_cmp;
    logic [TMR_W-1:0]             pseudo_sync_cmp;
    logic [TMR_W-1:0]             frame_ref_cmp;
    logic [TMR_W-1:0]             tape_write_cmp;
    logic [TMR_W-1:0]             sync_mask_cmp;
    logic [TMR_W-1:0]             duty_cmp_a;
    logic [TMR_W-1:0]             duty_cmp_b;
    logic [EV_W-1:0]              capstan_divider_cmp;
    logic [TMR_W-1:0]             general_cmp_a;
    logic [TMR_W-1:0]             general_cmp_b;
    logic [TAPE_W-1:0]            tape_count_cmp;
    logic [NUM_PWM-1:0][FINE_W-1:0]   fine_duty;
    logic [NUM_PWM-1:0][COARSE_W-1:0] coarse_duty;
    logic                         vsync_automask_en;
  } vst_cfg_t;

  typedef struct packed {
    logic [NUM_CAPT-1:0][FRC_W-1:0] phase_capture;
    logic [TMR_W-1:0]             capstan_phase_capture;
    logic [TMR_W-1:0]             playback_period_capture;
    logic [TMR_W-1:0]             remote_duty_capture;
    logic [TMR_W-1:0]             remote_period_capture;
    logic [TAPE_W-1:0]            tape_updown_counter;
  } vst_stat_t;
endpackage

// File: verilog/vst_sync.sv
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ns
`default_nettype none
module vst_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// File: verilog/vst_pwm.sv
// One PWM channel that scales a duty word onto the shared carrier period
`timescale 1ns/1ns
`default_nettype none
module vst_pwm #(
  parameter int W = 16
) (
  input  wire logic                           clk_sys,
  input  wire logic                           arst_n,
  input  wire logic [vst_pkg::CARRIER_W-1:0]  carrier,
  input  wire logic [W-1:0]                   duty,
  output var  logic                           pwm
);
  localparam logic [vst_pkg::CARRIER_W-1:0] PER = vst_pkg::CARRIER_W'(vst_pkg::PWM_PERIOD_CYC);
  logic [W+vst_pkg::CARRIER_W-1:0] prod;
  logic [vst_pkg::CARRIER_W-1:0]   thr;

  // The carrier period is not 2^W clocks long, so the duty word is scaled
  assign prod = duty * PER;
  assign thr  = prod[W+vst_pkg::CARRIER_W-1:W];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pwm <= 1'b0;
    end else begin
      pwm <= (carrier < thr);
    end
  end
endmodule
`default_nettype wire

// File: verilog/vcr_servo_timer_unit.sv
// Servo timer unit: head timing, capture counter, frame timers, tape counter and PWM
//
// How it works
// - Drum phase and speed pulses drive head switch and pseudo sync timing.
// - Head section: 8-bit event counter, four compares; 16-bit timer, three compares.
// - Any head timer compare match pulses the real-time output trigger.
// - Six captures latch the free counter; vertical and horizontal sync separated.
// - Frame timer makes tape write signal and capstan phase; duty timer does playback duty detection.
// - Frame timer has reference, tape write, sync mask compares and one capture.
// - Duty timer has two duty compares and a playback period capture.
// - Capstan speed pulses counted against a compare to divide frequency.
// - Sync mask match unmasks vertical sync and pulses a real-time trigger.
// - General timer A clears on compare match and pulses its interrupt.
// - General timer B clears on compare match and pulses its interrupt.
// - Remote edge copies remote timer into both remote captures.
// - Tape counter counts up on playback rise, down on fall.
// - Tape counter interrupts on compare match or underflow.
// - Three 16-bit PWM outputs, three 8-bit PWM outputs.
// - All PWM carriers run at 62.5 kHz.
// - Free counter advances every 125 ns, spanning 524 ms.
// - Free counter is 22 bits wide.
// - Head timer counts microseconds, spanning 65.5 ms.
// - Remote timer counts in 2 us steps, spanning 131 ms.
`timescale 1ns/1ns
`default_nettype none
module vcr_servo_timer_unit (
  input  wire logic                       clk_sys,
  input  wire logic                       arst_n,
  input  wire vst_pkg::vst_pins_t         pins,
  input  wire vst_pkg::vst_cfg_t          cfg,
  output wire vst_pkg::vst_stat_t         stat,
  output var  logic                       head_switch,
  output var  logic                       video_head_switch,
  output var  logic                       audio_head_switch,
  output var  logic                       pseudo_sync,
  output var  logic                       rtp_trig_head,
  output var  logic                       rtp_trig_mask,
  output var  logic                       vsync_sep,
  output var  logic                       hsync_sep,
  output var  logic                       tape_write_control,
  output var  logic [1:0]                 duty_level,
  output var  logic                       capstan_div_pulse,
  output var  logic [1:0]                 general_irq,
  output var  logic                       tape_irq,
  output var  logic [vst_pkg::NUM_PWM-1:0] fine_pwm,
  output var  logic [vst_pkg::NUM_PWM-1:0] coarse_pwm
);
  localparam int TW = vst_pkg::TMR_W;

  function automatic logic hit(input logic tk, input logic [TW-1:0] cnt, input logic [TW-1:0] cmp);
    return tk && (cnt == cmp);
  endfunction

  // Pins come from outside the clock domain
  vst_pkg::vst_pins_t pin_s;
  vst_pkg::vst_pins_t pin_d_r;
  logic [vst_pkg::PIN_W-1:0] pin_q;

  vst_sync #(.W(vst_pkg::PIN_W)) u_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .d       (pins),
    .q       (pin_q)
  );
  assign pin_s = vst_pkg::vst_pins_t'(pin_q);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_d_r <= '0;
    end else begin
      pin_d_r <= pin_s;
    end
  end

  logic pg_rise, fg_rise, cfg_rise, vs_rise, hs_rise, pb_rise, pb_fall, rm_rise;
  assign pg_rise  = pin_s.drum_phase_pulse & ~pin_d_r.drum_phase_pulse;
  assign fg_rise  = pin_s.drum_speed_pulse & ~pin_d_r.drum_speed_pulse;
  assign cfg_rise = pin_s.capstan_speed_pulse & ~pin_d_r.capstan_speed_pulse;
  assign vs_rise  = pin_s.vsync_in & ~pin_d_r.vsync_in;
  assign hs_rise  = pin_s.hsync_in & ~pin_d_r.hsync_in;
  assign pb_rise  = pin_s.playback_control_pulse & ~pin_d_r.playback_control_pulse;
  assign pb_fall  = ~pin_s.playback_control_pulse & pin_d_r.playback_control_pulse;
  assign rm_rise  = pin_s.remote_edge_input & ~pin_d_r.remote_edge_input;

  // Resolution ticks: a fractional accumulator keeps 125 ns exact on average
  logic [vst_pkg::TICK_N-1:0] tick_r;
  for (genvar g = 0; g < vst_pkg::TICK_N; g++) begin : g_tick
    localparam logic [vst_pkg::ACC_W-1:0] STEP = vst_pkg::ACC_W'(vst_pkg::CLK_NS);
    localparam logic [vst_pkg::ACC_W-1:0] PER  = vst_pkg::ACC_W'(vst_pkg::TICK_NS[g]);
    logic [vst_pkg::ACC_W-1:0] acc_r;
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        acc_r     <= '0;
        tick_r[g] <= 1'b0;
      end else if (acc_r + STEP >= PER) begin
        acc_r     <= acc_r + STEP - PER;
        tick_r[g] <= 1'b1;
      end else begin
        acc_r     <= acc_r + STEP;
        tick_r[g] <= 1'b0;
      end
    end
  end

  logic tk_frc, tk_us, tk_2us;
  assign tk_frc = tick_r[vst_pkg::TICK_FRC];
  assign tk_us  = tick_r[vst_pkg::TICK_US];
  assign tk_2us = tick_r[vst_pkg::TICK_2US];

  // Head event counter and its four compares
  logic [vst_pkg::EV_W-1:0] ev_cnt_r;
  logic [3:0]               ev_hit_r;
  logic                     head_sw_r;
  logic [TW-1:0]            head_timer_r;
  logic [2:0]               hm;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ev_cnt_r <= vst_pkg::EV_RST;
    end else if (pg_rise) begin
      ev_cnt_r <= vst_pkg::EV_RST;
    end else if (fg_rise) begin
      ev_cnt_r <= ev_cnt_r + 8'h01;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_ev
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        ev_hit_r[g] <= 1'b0;
      end else begin
        ev_hit_r[g] <= fg_rise && !pg_rise && (8'(ev_cnt_r + 8'h01) == cfg.head_event_cmp[g]);
      end
    end
  end

  // Internal head switch flips on each event match and restarts the delay timer
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      head_sw_r    <= 1'b0;
      head_timer_r <= vst_pkg::TMR_RST;
    end else if (|ev_hit_r) begin
      head_sw_r    <= ~head_sw_r;
      head_timer_r <= vst_pkg::TMR_RST;
    end else if (tk_us) begin
      head_timer_r <= head_timer_r + 16'h0001;
    end
  end

  assign hm[0] = hit(tk_us, head_timer_r, cfg.video_switch_cmp);
  assign hm[1] = hit(tk_us, head_timer_r, cfg.audio_switch_cmp);
  assign hm[2] = hit(tk_us, head_timer_r, cfg.pseudo_sync_cmp);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      head_switch       <= 1'b0;
      video_head_switch <= 1'b0;
      audio_head_switch <= 1'b0;
      pseudo_sync       <= 1'b0;
      rtp_trig_head     <= 1'b0;
    end else begin
      head_switch <= head_sw_r;
      if (hm[0]) begin
        video_head_switch <= head_sw_r;
      end
      if (hm[1]) begin
        audio_head_switch <= head_sw_r;
      end
      pseudo_sync   <= hm[2];
      rtp_trig_head <= |hm;
    end
  end

  // Free-running counter and its six captures
  logic [vst_pkg::FRC_W-1:0]                frc_r;
  logic [vst_pkg::NUM_CAPT-1:0][vst_pkg::FRC_W-1:0] cap_r;
  logic [vst_pkg::NUM_CAPT-1:0]             cap_src;
  logic vmask_r, vs_ok;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      frc_r <= vst_pkg::FRC_RST;
    end else if (tk_frc) begin
      frc_r <= frc_r + 22'h000001;
    end
  end

  // Masked vertical sync rejects noise until the mask compare reopens it
  assign vs_ok   = vs_rise & ~vmask_r;
  assign cap_src = {pin_s.reel_speed_b & ~pin_d_r.reel_speed_b,
                    pin_s.reel_speed_a & ~pin_d_r.reel_speed_a,
                    cfg_rise, fg_rise, pg_rise, vs_ok};

  for (genvar g = 0; g < vst_pkg::NUM_CAPT; g++) begin : g_cap
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        cap_r[g] <= vst_pkg::FRC_RST;
      end else if (cap_src[g]) begin
        cap_r[g] <= frc_r;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      vsync_sep <= 1'b0;
      hsync_sep <= 1'b0;
    end else begin
      vsync_sep <= vs_ok;
      hsync_sep <= hs_rise;
    end
  end

  // Frame reference timer
  logic [TW-1:0] fr_timer_r;
  logic [TW-1:0] cap_phase_r;
  logic          fr_hit, tw_hit, sm_hit;
  logic          div_hit;

  assign fr_hit = hit(tk_us, fr_timer_r, cfg.frame_ref_cmp);
  assign tw_hit = hit(tk_us, fr_timer_r, cfg.tape_write_cmp);
  assign sm_hit = hit(tk_us, fr_timer_r, cfg.sync_mask_cmp);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fr_timer_r <= vst_pkg::TMR_RST;
    end else if (vs_ok || fr_hit) begin
      fr_timer_r <= vst_pkg::TMR_RST;
    end else if (tk_us) begin
      fr_timer_r <= fr_timer_r + 16'h0001;
    end
  end

  // Setting the write pulse wins when both edges land together
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tape_write_control <= 1'b0;
    end else if (fr_hit) begin
      tape_write_control <= 1'b1;
    end else if (tw_hit) begin
      tape_write_control <= 1'b0;
    end
  end

  // Unmask wins over a new mask so a match is never lost
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      vmask_r       <= 1'b0;
      rtp_trig_mask <= 1'b0;
    end else begin
      rtp_trig_mask <= sm_hit;
      if (sm_hit) begin
        vmask_r <= 1'b0;
      end else if (vs_ok && cfg.vsync_automask_en) begin
        vmask_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cap_phase_r <= vst_pkg::TMR_RST;
    end else if (div_hit) begin
      cap_phase_r <= fr_timer_r;
    end
  end

  // Duty timer for the playback control pulse
  logic [TW-1:0] duty_timer_r;
  logic [TW-1:0] pb_period_r;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      duty_timer_r <= vst_pkg::TMR_RST;
      pb_period_r  <= vst_pkg::TMR_RST;
    end else if (pb_rise) begin
      pb_period_r  <= duty_timer_r;
      duty_timer_r <= vst_pkg::TMR_RST;
    end else if (tk_us) begin
      duty_timer_r <= duty_timer_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      duty_level <= 2'b00;
    end else begin
      if (hit(tk_us, duty_timer_r, cfg.duty_cmp_a)) begin
        duty_level[0] <= pin_s.playback_control_pulse;
      end
      if (hit(tk_us, duty_timer_r, cfg.duty_cmp_b)) begin
        duty_level[1] <= pin_s.playback_control_pulse;
      end
    end
  end

  // Capstan event divider
  logic [vst_pkg::EV_W-1:0] div_cnt_r;
  assign div_hit = cfg_rise && (8'(div_cnt_r + 8'h01) == cfg.capstan_divider_cmp);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_r         <= vst_pkg::EV_RST;
      capstan_div_pulse <= 1'b0;
    end else begin
      capstan_div_pulse <= div_hit;
      if (div_hit) begin
        div_cnt_r <= vst_pkg::EV_RST;
      end else if (cfg_rise) begin
        div_cnt_r <= div_cnt_r + 8'h01;
      end
    end
  end

  // Two general interval timers
  logic [1:0][TW-1:0] gen_cnt_r;
  logic [1:0][TW-1:0] gen_cmp;
  logic [1:0]         gen_tick;
  assign gen_cmp  = {cfg.general_cmp_b, cfg.general_cmp_a};
  assign gen_tick = {tk_2us, tk_us};

  for (genvar g = 0; g < 2; g++) begin : g_gen
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        gen_cnt_r[g]   <= vst_pkg::TMR_RST;
        general_irq[g] <= 1'b0;
      end else begin
        general_irq[g] <= hit(gen_tick[g], gen_cnt_r[g], gen_cmp[g]);
        if (hit(gen_tick[g], gen_cnt_r[g], gen_cmp[g])) begin
          gen_cnt_r[g] <= vst_pkg::TMR_RST;
        end else if (gen_tick[g]) begin
          gen_cnt_r[g] <= gen_cnt_r[g] + 16'h0001;
        end
      end
    end
  end

  // Remote decode timer runs free; software subtracts successive captures
  logic [TW-1:0] remote_timer_r;
  logic [TW-1:0] rm_duty_r;
  logic [TW-1:0] rm_period_r;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      remote_timer_r <= vst_pkg::TMR_RST;
    end else if (tk_2us) begin
      remote_timer_r <= remote_timer_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rm_duty_r   <= vst_pkg::TMR_RST;
      rm_period_r <= vst_pkg::TMR_RST;
    end else if (rm_rise) begin
      rm_duty_r   <= remote_timer_r;
      rm_period_r <= remote_timer_r;
    end
  end

  // Tape up/down counter; underflow wraps to all ones
  logic [vst_pkg::TAPE_W-1:0] udc_r;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      udc_r    <= vst_pkg::TAPE_RST;
      tape_irq <= 1'b0;
    end else if (pb_rise) begin
      udc_r    <= udc_r + 5'h01;
      tape_irq <= (5'(udc_r + 5'h01) == cfg.tape_count_cmp);
    end else if (pb_fall) begin
      udc_r    <= udc_r - 5'h01;
      tape_irq <= (udc_r == vst_pkg::TAPE_RST) || (5'(udc_r - 5'h01) == cfg.tape_count_cmp);
    end else begin
      tape_irq <= 1'b0;
    end
  end

  // Shared PWM carrier counter
  logic [vst_pkg::CARRIER_W-1:0] carrier_r;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      carrier_r <= '0;
    end else if (carrier_r == vst_pkg::CARRIER_W'(vst_pkg::PWM_PERIOD_CYC - 1)) begin
      carrier_r <= '0;
    end else begin
      carrier_r <= carrier_r + 10'h001;
    end
  end

  for (genvar g = 0; g < vst_pkg::NUM_PWM; g++) begin : g_pwm
    vst_pwm #(.W(vst_pkg::FINE_W)) u_fine (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .carrier (carrier_r),
      .duty    (cfg.fine_duty[g]),
      .pwm     (fine_pwm[g])
    );
    vst_pwm #(.W(vst_pkg::COARSE_W)) u_coarse (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .carrier (carrier_r),
      .duty    (cfg.coarse_duty[g]),
      .pwm     (coarse_pwm[g])
    );
  end

  assign stat.phase_capture           = cap_r;
  assign stat.capstan_phase_capture   = cap_phase_r;
  assign stat.playback_period_capture = pb_period_r;
  assign stat.remote_duty_capture     = rm_duty_r;
  assign stat.remote_period_capture   = rm_period_r;
  assign stat.tape_updown_counter     = udc_r;

  a_head_toggle: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (|ev_hit_r) |=> (head_sw_r != $past(head_sw_r)) && (head_timer_r == 16'h0000))
    else $error("head switch did not flip on event match");
  a_ev_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ev_hit_r[0] |=> !ev_hit_r[0])
    else $error("event match lasted more than one clock");
  a_frc_step: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tk_frc |=> !tk_frc ##1 !tk_frc ##1 !tk_frc ##1 !tk_frc ##1 !tk_frc)
    else $error("free counter tick faster than 125 ns");
  a_frc_count: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tk_frc |=> frc_r == 22'($past(frc_r) + 22'h000001))
    else $error("free counter did not advance on tick");
  a_cap_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !cap_src[1] |=> $stable(cap_r[1]))
    else $error("capture changed without an event");
  a_gen_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    general_irq[0] |-> (gen_cnt_r[0] == 16'h0000) && !$past(general_irq[0]))
    else $error("general timer not cleared with its interrupt");
  a_udc_up: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pb_rise |=> udc_r == 5'($past(udc_r) + 5'h01))
    else $error("tape counter did not count up");
  a_udc_under: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (pb_fall && udc_r == 5'h00) |=> tape_irq && udc_r == 5'h1f)
    else $error("tape underflow missed");
  a_tape_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
    fr_hit |=> tape_write_control && fr_timer_r == 16'h0000)
    else $error("tape write not raised on reference match");
  a_unmask: assert property (@(posedge clk_sys) disable iff (!arst_n)
    sm_hit |=> !vmask_r && rtp_trig_mask)
    else $error("sync mask match did not unmask");
  a_remote_cap: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rm_rise |=> rm_period_r == $past(remote_timer_r) && rm_duty_r == $past(remote_timer_r))
    else $error("remote capture wrong");
endmodule
`default_nettype wire

// File: dv/vst_motor_model.sv
// Behavioural motor and tape sense pulse source
`timescale 1ns/1ns
`default_nettype none
module vst_motor_model (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic [8:0] fire,
  output var  logic [8:0] pins
);
  logic [8:0][2:0] hold_r;
  // Four cycles high clears the two-cycle minimum the pin sync needs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) hold_r <= '0;
    else for (int i = 0; i < 9; i++) hold_r[i] <= fire[i] ? 3'h4 : hold_r[i] - 3'(hold_r[i] != 3'h0);
  end
  always_comb for (int i = 0; i < 9; i++) pins[i] = hold_r[i] != 3'h0;
endmodule
`default_nettype wire

// File: dv/vcr_servo_timer_unit_tb.sv
// Self-checking bench for the servo timer unit
`timescale 1ns/1ns
`default_nettype none
module vcr_servo_timer_unit_tb;
  logic               clk_sys;
  logic               arst_n;
  logic [8:0]         fire;
  logic [8:0]         pins_w;
  vst_pkg::vst_cfg_t  cfg;
  vst_pkg::vst_stat_t stat;
  logic [1:0]         girq;
  logic               tirq;
  logic               hsw;
  logic [2:0]         fpwm;
  logic [2:0]         cpwm;
  logic               vhs, psy, rth, vsp, twc, cdp;
  logic [4:0]         exp_q[$];
  logic [31:0]        seed;
  logic [21:0]        f0;
  logic [15:0]        r0;
  int                 bad_count = 0, total_checks = 0, cyc = 0, ta = 0, tb = 0, da, db, hi_f, hi_c, nirq = 0;
  int                 hi_w = 0, nps = 0, nrt = 0, nvs = 0, ndv = 0;

  vcr_servo_timer_unit i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .pins(vst_pkg::vst_pins_t'(pins_w)),
    .cfg(cfg), .stat(stat), .head_switch(hsw), .video_head_switch(vhs), .audio_head_switch(), .pseudo_sync(psy),
    .rtp_trig_head(rth), .rtp_trig_mask(), .vsync_sep(vsp), .hsync_sep(), .tape_write_control(twc), .duty_level(),
    .capstan_div_pulse(cdp), .general_irq(girq), .tape_irq(tirq), .fine_pwm(fpwm), .coarse_pwm(cpwm));
  vst_motor_model i_model (.clk_sys(clk_sys), .arst_n(arst_n), .fire(fire), .pins(pins_w));

  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL %s exp %0h got %0h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic pulse(logic [8:0] m);
    @(posedge clk_sys) fire <= m;
    @(posedge clk_sys) fire <= 9'h000;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Sampled on the falling edge so registered outputs have settled
  always @(negedge clk_sys) begin
    cyc++;
    hi_f += fpwm[0];
    hi_c += cpwm[0];
    hi_w += twc;
    nps += psy;
    nrt += rth;
    nvs += vsp;
    ndv += cdp;
    if (girq[0]) begin da = cyc - ta; ta = cyc; end
    if (girq[1]) begin db = cyc - tb; tb = cyc; end
    if (tirq) begin
      nirq++;
      if (exp_q.size() > 0) check("tape irq value", 32'(stat.tape_updown_counter), 32'(exp_q.pop_front()));
      else check("tape irq spare", 32'h1, 32'h0);
    end
  end

  initial begin
    arst_n = 1'b0;
    fire = 9'h000;
    cfg = '0;
    seed = xs(32'd77678);
    cfg.general_cmp_a = 16'h0003;
    cfg.general_cmp_b = 16'h0002;
    cfg.tape_count_cmp = 5'h01;
    cfg.head_event_cmp[0] = 8'h03;
    cfg.frame_ref_cmp = 16'h0007;
    cfg.tape_write_cmp = 16'h0003;
    cfg.sync_mask_cmp = 16'h0005;
    cfg.capstan_divider_cmp = 8'h02;
    cfg.vsync_automask_en = 1'b1;
    cfg.fine_duty[0] = 16'h8000;
    cfg.coarse_duty[0] = seed[7:0];
    tick(12);
    arst_n <= 1'b1;
    tick(1700);
    hi_f = 0;
    hi_c = 0;
    hi_w = 0;
    tick(800);
    check("fine pwm high", hi_f, 400);
    check("coarse pwm high", hi_c, (32'(seed[7:0]) * 32'd800) >> 8);
    // Frame of 8 us, write pulse high for 4 us of it
    check("tape write high", hi_w, 400);
    pulse(9'h101);
    tick(20);
    f0 = stat.phase_capture[1];
    r0 = stat.remote_period_capture;
    check("remote pair", stat.remote_duty_capture, r0);
    tick(978);
    pulse(9'h101);
    tick(20);
    check("free span", 22'(stat.phase_capture[1] - f0), 160);
    check("remote span", 16'(stat.remote_period_capture - r0), 10);
    f0 = stat.phase_capture[1];
    tick(300);
    check("capture hold", stat.phase_capture[1], f0);
    pulse(9'h080);
    tick(10);
    pulse(9'h080);
    tick(10);
    check("head early", hsw, 0);
    pulse(9'h080);
    tick(10);
    check("head toggle", hsw, 1);
    exp_q.push_back(5'h01);
    pulse(9'h002);
    tick(20);
    check("tape after fall", stat.tape_updown_counter, 0);
    exp_q.push_back(5'h01);
    pulse(9'h002);
    tick(20);
    check("tape irq count", nirq, 2);
    repeat (2) begin
      pulse(9'h040);
      tick(10);
    end
    check("divider pulses", ndv, 1);
    // Second vsync lands while the mask is still closed
    repeat (2) begin
      pulse(9'h008);
      tick(10);
    end
    check("vsync accepted", nvs, 1);
    check("video switch", vhs, 1);
    check("pseudo sync pulses", nps, 2);
    check("head trigger pulses", nrt, 2);
    check("timer a gap", da, 200);
    check("timer b gap", db, 300);
    print_verdict();
  end

  initial begin
    tick(20000);
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
